// [usart_modem_handshake_rx.sv]
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - carrier detect counts as asserted when high
// - back-to-back chars then break: framing error, no break
// - one stop honoured; then idle, break armed after a full idle bit
// - handshake mode drops request-to-send at once
// - receiver disable leaves request-to-send unchanged
// - in handshake mode request-to-send high only after both counters zero
module usart_modem_handshake_rx
  import usart_hs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              rxd,
  input  wire logic              dcdIn,
  output logic                   txdOut,
  output logic                   txdOe,
  output logic                   rtsN,
  output logic                   irq,
  output logic                   dmaWrStb,
  output logic      [7:0]        dmaWrData
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0]       ctrl_r, ctrl_nxt;
  logic [15:0]       mask_r, mask_nxt;
  logic [15:0]       baud_r, baud_nxt;
  logic [15:0]       rcnt_r, rcnt_nxt;
  logic [15:0]       rncnt_r, rncnt_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              rts_r, rts_nxt;
  logic              irq_r, irq_nxt;
  logic              dmaStb_r, dmaStb_nxt;
  logic [7:0]        dmaDat_r, dmaDat_nxt;
  logic [7:0]        rxHold_r, rxHold_nxt;
  rx_state_type      st_r, st_nxt;
  logic [15:0]       tick_r, tick_nxt;
  logic [3:0]        bitCnt_r, bitCnt_nxt;
  logic [7:0]        shift_r, shift_nxt;
  logic              brkArm_r, brkArm_nxt;
  logic              lowAll_r, lowAll_nxt;
  logic              dcdPrev_r;
  logic [ST_W-1:0]   stat;
  logic [ST_W-1:0]   setEv;
  logic [ST_W-1:0]   clrEv;
  logic              evRxrdy, evFrame, evBrk, evFull, evDcd;
  logic              dcdAct;
  logic              wrCtrl, wrCnt, wrNcnt;
  logic              rxEn, dmaEn, hsMode;
  logic [15:0]       half;

  assign rxEn   = ctrl_r[CTRL_RXEN];
  assign dmaEn  = ctrl_r[CTRL_DMAEN];
  assign hsMode = ctrl_r[CTRL_HSMODE];
  assign dcdAct = dcdIn;
  assign half   = {1'b0, baud_r[15:1]};
  assign wrCtrl = regWr && (regAddr == OFF_CTRL);
  assign wrCnt  = regWr && (regAddr == OFF_RCOUNT);
  assign wrNcnt = regWr && (regAddr == OFF_RNCOUNT);

  // ************************************************************
  // interrupt flags
  // ************************************************************
  assign setEv = {evDcd, evFull, evBrk, evFrame, evRxrdy};
  assign clrEv = (regWr && regAddr == OFF_STATUS) ? regWdata[ST_W-1:0] : '0;
  genvar gi;
  generate
    for (gi = 0; gi < ST_W; gi++) begin : g_flag
      sticky_bit u_flag (
        .core_clk (core_clk),
        .rstn     (rstn),
        .setEv    (setEv[gi]),
        .clrEv    (clrEv[gi]),
        .flag     (stat[gi])
      );
    end
  endgenerate

  // ************************************************************
  // receiver
  // ************************************************************
  always_comb begin
    st_nxt     = st_r;
    tick_nxt   = tick_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt  = shift_r;
    brkArm_nxt = brkArm_r;
    lowAll_nxt = lowAll_r;
    rxHold_nxt = rxHold_r;
    evRxrdy    = 1'b0;
    evFrame    = 1'b0;
    evBrk      = 1'b0;
    case (st_r)
      RX_IDLE: begin
        tick_nxt = '0;
        if (rxEn && !rxd) begin
          st_nxt = RX_START;
        end else if (rxd && tick_r >= baud_r) begin
          // a full bit of idle line after the stop arms break detection
          tick_nxt   = tick_r;
          brkArm_nxt = 1'b1;
        end else if (rxd) begin
          tick_nxt = tick_r + 16'h0001;
        end
      end
      RX_START: begin
        tick_nxt = tick_r + 16'h0001;
        if (tick_r >= half) begin
          tick_nxt   = '0;
          bitCnt_nxt = '0;
          lowAll_nxt = !rxd;
          st_nxt     = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        tick_nxt = tick_r + 16'h0001;
        if (tick_r >= baud_r) begin
          tick_nxt   = '0;
          shift_nxt  = {rxd, shift_r[7:1]};
          lowAll_nxt = lowAll_r && !rxd;
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (bitCnt_r == DATA_BITS - 4'h1) begin
            st_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        tick_nxt = tick_r + 16'h0001;
        if (tick_r >= baud_r) begin
          tick_nxt = '0;
          // only a single stop is sampled per character
          if (rxd) begin
            evRxrdy    = 1'b1;
            rxHold_nxt = shift_r;
            // disarmed until the line idles a full bit, so a start
            // straight after this stop finds break detection off
            brkArm_nxt = 1'b0;
            st_nxt     = RX_IDLE;
          end else if (lowAll_r && brkArm_r) begin
            evBrk  = 1'b1;
            st_nxt = RX_BREAK;
          end else begin
            // break directly after a back-to-back char is seen as bad framing
            evFrame    = 1'b1;
            brkArm_nxt = 1'b0;
            st_nxt     = lowAll_r ? RX_BREAK : RX_IDLE;
          end
        end
      end
      RX_BREAK: begin
        if (rxd) begin
          brkArm_nxt = 1'b1;
          st_nxt     = RX_IDLE;
        end
      end
      default: st_nxt = RX_IDLE;
    endcase
  end

  // ************************************************************
  // dma counters and request-to-send
  // ************************************************************
  always_comb begin
    rcnt_nxt   = rcnt_r;
    rncnt_nxt  = rncnt_r;
    dmaStb_nxt = 1'b0;
    dmaDat_nxt = dmaDat_r;
    evFull     = 1'b0;
    if (evRxrdy && dmaEn && rcnt_r != COUNT_RST) begin
      dmaStb_nxt = 1'b1;
      dmaDat_nxt = rxHold_nxt;
      if (rcnt_r == 16'h0001) begin
        rcnt_nxt  = rncnt_r;
        rncnt_nxt = COUNT_RST;
        evFull    = (rncnt_r == COUNT_RST);
      end else begin
        rcnt_nxt = rcnt_r - 16'h0001;
      end
    end
    if (wrCnt) begin
      rcnt_nxt = regWdata;
    end
    if (wrNcnt) begin
      rncnt_nxt = regWdata;
    end
    rts_nxt = rts_r;
    if (wrCtrl && regWdata[CTRL_HSMODE] && !hsMode) begin
      rts_nxt = 1'b0;
    end else if (hsMode && rcnt_nxt == COUNT_RST && rncnt_nxt == COUNT_RST
                 && (wrCnt || wrNcnt || evFull)) begin
      rts_nxt = 1'b1;
    end else if (hsMode && (rcnt_nxt != COUNT_RST || rncnt_nxt != COUNT_RST)) begin
      rts_nxt = rts_r && !(wrCnt || wrNcnt);
    end
    if (!hsMode && !(wrCtrl && regWdata[CTRL_HSMODE])) begin
      rts_nxt = 1'b1;
    end
    // receiver enable bit plays no part above, so disabling it leaves rts alone
  end

  // ************************************************************
  // register bus
  // ************************************************************
  always_comb begin
    ctrl_nxt  = ctrl_r;
    mask_nxt  = mask_r;
    baud_nxt  = baud_r;
    rdata_nxt = '0;
    if (wrCtrl) begin
      ctrl_nxt = regWdata;
    end
    if (regWr && regAddr == OFF_MASK) begin
      mask_nxt = regWdata;
    end
    if (regWr && regAddr == OFF_BAUD) begin
      baud_nxt = regWdata;
    end
    if (regRd) begin
      case (regAddr)
        OFF_CTRL:    rdata_nxt = ctrl_r;
        OFF_STATUS:  rdata_nxt = {{(16-ST_W){1'b0}}, stat};
        OFF_MASK:    rdata_nxt = mask_r;
        OFF_RXDATA:  rdata_nxt = {8'h00, rxHold_r};
        OFF_RCOUNT:  rdata_nxt = rcnt_r;
        OFF_RNCOUNT: rdata_nxt = rncnt_r;
        OFF_BAUD:    rdata_nxt = baud_r;
        OFF_LINES:   rdata_nxt = {13'h0000, dcdAct, rts_r, rxd};
        default:     rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(stat & mask_r[ST_W-1:0]);
  end

  assign evDcd = ctrl_r[CTRL_MODEM] && dcdAct && !dcdPrev_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_r     <= CTRL_RST;
      mask_r     <= 16'h0000;
      baud_r     <= BAUD_RST;
      rcnt_r     <= COUNT_RST;
      rncnt_r    <= COUNT_RST;
      rdata_r    <= '0;
      rts_r      <= 1'b1;
      irq_r      <= 1'b0;
      dmaStb_r   <= 1'b0;
      dmaDat_r   <= 8'h00;
      rxHold_r   <= 8'h00;
      st_r       <= RX_IDLE;
      tick_r     <= 16'h0000;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      brkArm_r   <= 1'b1;
      lowAll_r   <= 1'b0;
      dcdPrev_r  <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      mask_r     <= mask_nxt;
      baud_r     <= baud_nxt;
      rcnt_r     <= rcnt_nxt;
      rncnt_r    <= rncnt_nxt;
      rdata_r    <= rdata_nxt;
      rts_r      <= rts_nxt;
      irq_r      <= irq_nxt;
      dmaStb_r   <= dmaStb_nxt;
      dmaDat_r   <= dmaDat_nxt;
      rxHold_r   <= rxHold_nxt;
      st_r       <= st_nxt;
      tick_r     <= tick_nxt;
      bitCnt_r   <= bitCnt_nxt;
      shift_r    <= shift_nxt;
      brkArm_r   <= brkArm_nxt;
      lowAll_r   <= lowAll_nxt;
      dcdPrev_r  <= dcdAct;
    end
  end

  assign regRdata  = rdata_r;
  assign rtsN      = rts_r;
  assign irq       = irq_r;
  assign dmaWrStb  = dmaStb_r;
  assign dmaWrData = dmaDat_r;
  // transmit pin is released; an outside pull-up keeps it at idle
  assign txdOut    = 1'b1;
  assign txdOe     = 1'b0;

  // ************************************************************
  // checks
  // ************************************************************
  sequence hs_enter;
    wrCtrl && regWdata[CTRL_HSMODE] && !hsMode;
  endsequence
  chk_hs_rts_low: assert property (@(posedge core_clk) disable iff (!rstn)
    hs_enter |=> !rtsN) else $error("rts not low after handshake entry");
  chk_rxen_rts_keep: assert property (@(posedge core_clk) disable iff (!rstn)
    (wrCtrl && hsMode && regWdata[CTRL_HSMODE] && !regWdata[CTRL_RXEN] && rxEn
     && !wrCnt && !wrNcnt && !evFull) |=> $stable(rtsN)) else $error("rx disable moved rts");
  chk_rts_rise_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (hsMode && $rose(rtsN)) |-> (rcnt_r == 0 && rncnt_r == 0)) else $error("rts rose early");
  chk_rts_space_low: assert property (@(posedge core_clk) disable iff (!rstn)
    (hsMode && !rtsN && rcnt_r != 0) |=> !rtsN || !hsMode || rcnt_r == 0)
    else $error("rts rose with space left");
  chk_stop_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_r == RX_STOP && evRxrdy) |=> (st_r == RX_IDLE && !brkArm_r))
    else $error("stop not idle");
  chk_idle_arm: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_r == RX_IDLE && rxd && tick_r >= baud_r) |=> brkArm_r)
    else $error("idle did not arm break");
  chk_noguard_frame: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_r == RX_STOP && tick_r >= baud_r && !rxd && !brkArm_r) |-> (evFrame && !evBrk))
    else $error("unarmed break not framing error");
  chk_dcd_high: assert property (@(posedge core_clk) disable iff (!rstn)
    (ctrl_r[CTRL_MODEM] && $rose(dcdIn)) |=> stat[ST_DCD]) else $error("dcd high missed");
  chk_txd_float: assert property (@(posedge core_clk) disable iff (!rstn)
    !txdOe) else $error("txd driven");
endmodule

// [usart_hs_pkg.sv]
package usart_hs_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_STATUS    = 4'h1;
  localparam logic [3:0]  OFF_MASK      = 4'h2;
  localparam logic [3:0]  OFF_RXDATA    = 4'h3;
  localparam logic [3:0]  OFF_RCOUNT    = 4'h4;
  localparam logic [3:0]  OFF_RNCOUNT   = 4'h5;
  localparam logic [3:0]  OFF_BAUD      = 4'h6;
  localparam logic [3:0]  OFF_LINES     = 4'h7;
  // ************************************************************
  // control fields
  // ************************************************************
  localparam int          CTRL_RXEN     = 0;
  localparam int          CTRL_HSMODE   = 1;
  localparam int          CTRL_MODEM    = 2;
  localparam int          CTRL_DMAEN    = 3;
  // ************************************************************
  // status fields
  // ************************************************************
  localparam int          ST_RXRDY      = 0;
  localparam int          ST_FRAME      = 1;
  localparam int          ST_BRK        = 2;
  localparam int          ST_BUFFULL    = 3;
  localparam int          ST_DCD        = 4;
  localparam int          ST_W          = 5;
  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] BAUD_RST      = 16'h0010;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [3:0]  DATA_BITS     = 4'h8;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BREAK} rx_state_type;
endpackage

// [sticky_bit.sv]
`timescale 1ns/1ps
module sticky_bit (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic setEv,
  input  wire logic clrEv,
  output logic      flag
);
  logic flag_r;
  logic flag_nxt;
  // set wins over a clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (clrEv) begin
      flag_nxt = 1'b0;
    end
    if (setEv) begin
      flag_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag = flag_r;
endmodule

// [serial_remote_model.sv]
`timescale 1ns/1ps
module serial_remote_model #(
  parameter int BIT_CYC = 17
) (
  input  wire logic core_clk,
  input  wire logic txdOut,
  input  wire logic txdOe,
  output logic      txdLine,
  output logic      rxd
);
  // ************************************************************
  // released transmit line
  // ************************************************************
  // the pull-up is what holds idle while the block leaves the line undriven
  assign txdLine = txdOe ? txdOut : 1'b1;

  initial rxd = 1'b1;

  // ************************************************************
  // remote transmitter, 8 data bits lsb first
  // ************************************************************
  // callers enter just after a rising edge, so frames can abut with no idle cycle
  task automatic sendBit(input logic b);
    rxd <= b;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask

  // zero data with a low stop level makes a break; guard counts idle bit times
  task automatic sendFrame(input logic [7:0] d, input logic stopLvl, input int stops,
                           input int guard);
    sendBit(1'b0);
    for (int i = 0; i < 8; i++) begin
      sendBit(d[i]);
    end
    sendBit(stopLvl);
    for (int i = 1; i < stops; i++) begin
      sendBit(1'b1);
    end
    if (guard > 0) begin
      rxd <= 1'b1;
      repeat (guard * BIT_CYC) @(posedge core_clk);
    end
  endtask
endmodule

// [tb_usart_modem_handshake_rx.sv]
`timescale 1ns/1ps
module tb_usart_modem_handshake_rx;
  import usart_hs_pkg::*;
  logic              core_clk;
  logic              rstn;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdata;
  logic              rxd;
  logic              dcdIn;
  logic              txdOut;
  logic              txdOe;
  logic              txdLine;
  logic              rtsN;
  logic              irq;
  logic              dmaWrStb;
  logic [7:0]        dmaWrData;
  logic [7:0]        dmaLast;
  int                dmaCount;
  int                mismatches;
  int                checkCount;
  int                cycles;

  usart_modem_handshake_rx usart_modem_handshake_rx_i (
    .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxd(rxd), .dcdIn(dcdIn),
    .txdOut(txdOut), .txdOe(txdOe), .rtsN(rtsN), .irq(irq), .dmaWrStb(dmaWrStb),
    .dmaWrData(dmaWrData));

  serial_remote_model #(.BIT_CYC(int'(BAUD_RST) + 1)) serial_remote_model_i (
    .core_clk(core_clk), .txdOut(txdOut), .txdOe(txdOe), .txdLine(txdLine), .rxd(rxd));

  // ************************************************************
  // clock, watchdog, dma monitor
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      test_done();
    end
    if (dmaWrStb === 1'b1) begin
      dmaCount++;
      dmaLast = dmaWrData;
    end
  end

  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chkBit(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1 check("regRdata", regRdata, exp);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rstn = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    dcdIn = 1'b0;
    dmaCount = 0;
    mismatches = 0;
    checkCount = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_BAUD, BAUD_RST);
    rd(OFF_RCOUNT, COUNT_RST);
    rd(OFF_STATUS, 16'h0000);
    rd(4'hF, 16'h0000);
    chkBit("rtsN", rtsN, 1'b1);
    chkBit("txdLine", txdLine, 1'b1);
    // carrier detect asserted at high level, reported through the interrupt
    wr(OFF_CTRL, 16'h0004);
    dcdIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFF_STATUS, 16'h0010);
    wr(OFF_MASK, 16'h0010);
    repeat (2) @(posedge core_clk);
    #1 chkBit("irq", irq, 1'b1);
    wr(OFF_STATUS, 16'h0010);
    repeat (2) @(posedge core_clk);
    #1 chkBit("irq", irq, 1'b0);
    wr(OFF_MASK, 16'h0000);
    // handshake selected while the receiver is still off
    wr(OFF_CTRL, 16'h0006);
    @(posedge core_clk);
    #1 chkBit("rtsN", rtsN, 1'b0);
    wr(OFF_CTRL, 16'h000F);
    wr(OFF_RCOUNT, 16'h0001);
    wr(OFF_RNCOUNT, 16'h0001);
    wr(OFF_CTRL, 16'h000E);
    #1 chkBit("rtsN", rtsN, 1'b0);
    wr(OFF_CTRL, 16'h000F);
    // two bytes exhaust current and next buffers
    serial_remote_model_i.sendFrame(8'hA5, 1'b1, 1, 1);
    check("dmaCount", 16'(dmaCount), 16'h0001);
    check("dmaData", {8'h00, dmaLast}, 16'h00A5);
    chkBit("rtsN", rtsN, 1'b0);
    serial_remote_model_i.sendFrame(8'h3C, 1'b1, 1, 1);
    check("dmaData", {8'h00, dmaLast}, 16'h003C);
    rd(OFF_RXDATA, 16'h003C);
    rd(OFF_RNCOUNT, COUNT_RST);
    rd(OFF_STATUS, 16'h0009);
    chkBit("rtsN", rtsN, 1'b1);
    // only zeroing both counters brings the line back up
    wr(OFF_RCOUNT, 16'h0002);
    wr(OFF_RNCOUNT, 16'h0002);
    wr(OFF_CTRL, 16'h0005);
    wr(OFF_CTRL, 16'h0007);
    wr(OFF_RCOUNT, 16'h0000);
    @(posedge core_clk);
    #1 chkBit("rtsN", rtsN, 1'b0);
    wr(OFF_RNCOUNT, 16'h0000);
    @(posedge core_clk);
    #1 chkBit("rtsN", rtsN, 1'b1);
    rd(OFF_LINES, 16'h0007);
    wr(OFF_STATUS, 16'h001F);
    wr(OFF_CTRL, 16'h0001);
    // break right behind a character with no guard time is a framing error
    serial_remote_model_i.sendFrame(8'h55, 1'b1, 1, 0);
    serial_remote_model_i.sendFrame(8'h00, 1'b0, 1, 2);
    rd(OFF_STATUS, 16'h0003);
    wr(OFF_STATUS, 16'h001F);
    // a second stop lets the receiver idle and arm break detection
    serial_remote_model_i.sendFrame(8'h55, 1'b1, 2, 0);
    serial_remote_model_i.sendFrame(8'h00, 1'b0, 1, 2);
    rd(OFF_STATUS, 16'h0005);
    test_done();
  end
endmodule
